// >>> include/drlb_regs.vh
// Register codes, field positions, reset values and timing counts for the dual rate indicator blinker.
`ifndef DRLB_REGS_VH
`define DRLB_REGS_VH
`define DRLB_PTR_PIN_STATE      3'h0
`define DRLB_PTR_ZERO_PRESCALER 3'h1
`define DRLB_PTR_ZERO_DUTY      3'h2
`define DRLB_PTR_ONE_PRESCALER  3'h3
`define DRLB_PTR_ONE_DUTY       3'h4
`define DRLB_PTR_SELECTOR       3'h5
`define DRLB_PTR_LAST           3'h5
`define DRLB_CMD_AUTO_STEP_BIT  4
`define DRLB_RST_PRESCALER      8'hFF
`define DRLB_RST_DUTY           8'h80
`define DRLB_RST_SELECTOR       8'h55
`define DRLB_SEL_LOW            2'h0
`define DRLB_SEL_RELEASE        2'h1
`define DRLB_SEL_BLINK_ZERO     2'h2
`define DRLB_SEL_BLINK_ONE      2'h3
`define DRLB_CLK_HZ             100000000
`define DRLB_STEP_RATE_HZ       (44 * 256)
`define DRLB_STEP_CYCLES        (`DRLB_CLK_HZ / `DRLB_STEP_RATE_HZ)
`define DRLB_SLAVE_ADDR         7'h62
`endif

// >>> hw/drlb_blink.v
// One blink source: prescaled 256-step cycle counter compared with a duty threshold.
`timescale 1ns/1ns
`include "drlb_regs.vh"
module drlb_blink #(
   parameter STEP_CYCLES = `DRLB_STEP_CYCLES
)(
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire [7:0] prescaler_i,
   input  wire [7:0] duty_i,
   output reg        blink_o
);
   reg  [31:0] tick_r;
   reg  [7:0]  pre_r;
   reg  [7:0]  count_r;
   wire        tick_done = (tick_r >= STEP_CYCLES - 1);

   // Each count step lasts (prescaler + 1) steps of 1/(44*256) s.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tick_r  <= 32'h0;
         pre_r   <= 8'h00;
         count_r <= 8'h00;
         blink_o <= 1'b0;
      end
      else
      begin
         tick_r <= tick_done ? 32'h0 : tick_r + 32'h1;
         if (tick_done)
         begin
            if (pre_r >= prescaler_i) // see [RULE_04] see [RULE_23]
            begin
               pre_r   <= 8'h00;
               count_r <= count_r + 8'h01; // see [RULE_25]
            end
            else
               pre_r <= pre_r + 8'h01;
         end
         // Low below the threshold, high at or above it; a zero threshold holds it low.
         blink_o <= (duty_i != 8'h00) && (count_r >= duty_i); // see [RULE_01] see [RULE_02] see [RULE_03] see [RULE_05] see [RULE_06] see [RULE_07]
      end
   end
endmodule // drlb_blink

// >>> hw/drlb_top.v
// Dual rate indicator blinker with a two-wire serial slave port.
`timescale 1ns/1ns
`include "drlb_regs.vh"
// Operation
// [RULE_01] Source zero is low while count is below first threshold, high above.
// [RULE_02] First threshold zero keeps source zero low all period.
// [RULE_03] Source zero duty equals (256 minus first threshold) over 256.
// [RULE_04] Source one period is (second prescaler plus one) over 44 seconds.
// [RULE_05] Source one is low while count is below second threshold, high above.
// [RULE_06] Second threshold zero keeps source one low.
// [RULE_07] Source one duty equals (256 minus second threshold) over 256.
// [RULE_08] Selector codes: low, release, follow source zero, follow source one.
// [RULE_09] Selector fields per output, bits 7:6 down to 1:0, default release.
// [RULE_10] Controller releases a pin before reading it as an input.
// [RULE_11] Released pin reads high, low-programmed pin reads low, blinking allowed.
// [RULE_12] After power-on reset all registers take defaults, outputs off.
// [RULE_13] Master starts transfers only while both lines are high.
// [RULE_14] Data stable during clock high; changes there are control conditions.
// [RULE_15] Data fall with clock high is START, rise is STOP.
// [RULE_16] Each byte is followed by one acknowledge bit; byte count unlimited.
// [RULE_17] Device acknowledges every byte it receives when addressed.
// [RULE_18] Master acknowledges every read byte except the last.
// [RULE_19] Acknowledger holds data low through the acknowledge clock high.
// [RULE_20] Missing master acknowledge ends a read; device releases data.
// [RULE_21] Low three command bits are the pointer; auto step wraps after last.
// [RULE_22] Pointer codes 0 to 5 select pin state, prescalers, thresholds, selector.
// [RULE_23] Source zero period is (first prescaler plus one) over 44 seconds.
// [RULE_24] Pin-state register shows live pins; writes change nothing.
// [RULE_25] Each source counts 256 steps per period; equal counts read high.
module drlb_top #(
   parameter STEP_CYCLES = `DRLB_STEP_CYCLES,
   parameter [6:0] SLAVE_ADDR = `DRLB_SLAVE_ADDR
)(
   input  wire       MCLK_I,
   input  wire       RESET_I,
   input  wire       SCL_I,
   input  wire       SDA_I,
   output reg        SDA_O,
   output reg        SDA_OE_O,
   input  wire [3:0] IND_I,
   output reg  [3:0] IND_O,
   output reg  [3:0] IND_OE_O
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_CMD  = 3'h2;
   localparam ST_WR   = 3'h3;
   localparam ST_RD   = 3'h4;
   localparam ST_RACK = 3'h5;
   localparam ST_SKIP = 3'h6;

   reg  [1:0] scl_s_r;
   reg  [1:0] sda_s_r;
   reg  [3:0] ind_meta_r;
   reg  [3:0] ind_sync_r;
   reg        scl_d_r;
   reg        sda_d_r;
   reg  [2:0] state_r;
   reg  [3:0] bit_r;
   reg  [7:0] shift_r;
   reg        ack_phase_r;
   reg  [2:0] ptr_r;
   reg        auto_r;
   reg  [7:0] zero_prescaler_r;
   reg  [7:0] blink_zero_duty_threshold_r;
   reg  [7:0] blink_one_period_prescaler_r;
   reg  [7:0] blink_one_duty_threshold_r;
   reg  [7:0] output_source_selector_r;
   wire       blink_source_zero;
   wire       blink_source_one;
   wire [7:0] rd_byte;
   wire       scl = scl_s_r[1];
   wire       sda = sda_s_r[1];
   wire       scl_rise = scl & ~scl_d_r;
   wire       scl_fall = ~scl & scl_d_r;
   wire       start_cond = scl & scl_d_r & sda_d_r & ~sda; // see [RULE_15]
   wire       stop_cond  = scl & scl_d_r & ~sda_d_r & sda; // see [RULE_15]
   integer    k;

   // Pointer advance with wrap after the last register.
   function [2:0] next_ptr;
      input [2:0] p;
      begin
         next_ptr = (p >= `DRLB_PTR_LAST) ? 3'h0 : p + 3'h1; // see [RULE_21]
      end
   endfunction

   // Register read multiplexer.
   function [7:0] read_reg;
      input [2:0] p;
      begin
         case (p) // see [RULE_22]
            `DRLB_PTR_PIN_STATE:      read_reg = {4'h0, ind_sync_r}; // see [RULE_24] see [RULE_10]
            `DRLB_PTR_ZERO_PRESCALER: read_reg = zero_prescaler_r;
            `DRLB_PTR_ZERO_DUTY:      read_reg = blink_zero_duty_threshold_r;
            `DRLB_PTR_ONE_PRESCALER:  read_reg = blink_one_period_prescaler_r;
            `DRLB_PTR_ONE_DUTY:       read_reg = blink_one_duty_threshold_r;
            `DRLB_PTR_SELECTOR:       read_reg = output_source_selector_r;
            default:                  read_reg = 8'h00;
         endcase
      end
   endfunction

   assign rd_byte = read_reg(ptr_r);

   drlb_blink #(.STEP_CYCLES(STEP_CYCLES)) u_blink_zero (
      .clk_i       (MCLK_I),
      .rst_i       (RESET_I),
      .prescaler_i (zero_prescaler_r),
      .duty_i      (blink_zero_duty_threshold_r),
      .blink_o     (blink_source_zero)
   );

   drlb_blink #(.STEP_CYCLES(STEP_CYCLES)) u_blink_one (
      .clk_i       (MCLK_I),
      .rst_i       (RESET_I),
      .prescaler_i (blink_one_period_prescaler_r),
      .duty_i      (blink_one_duty_threshold_r),
      .blink_o     (blink_source_one)
   );

   // Two-stage synchronisers for bus lines and pins.
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         scl_s_r    <= 2'h3;
         sda_s_r    <= 2'h3;
         ind_meta_r <= 4'hF;
         ind_sync_r <= 4'hF;
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
      end
      else
      begin
         scl_s_r    <= {scl_s_r[0], SCL_I};
         sda_s_r    <= {sda_s_r[0], SDA_I};
         ind_meta_r <= IND_I;
         ind_sync_r <= ind_meta_r;
         scl_d_r    <= scl;
         sda_d_r    <= sda;
      end
   end

   // Pin drivers follow the selector fields.
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         IND_O    <= 4'h0;
         IND_OE_O <= 4'h0; // see [RULE_12]
      end
      else
      begin
         for (k = 0; k < 4; k = k + 1)
         begin
            IND_O[k] <= 1'b0;
            case (output_source_selector_r[2*k +: 2]) // see [RULE_08] see [RULE_09] see [RULE_11]
               `DRLB_SEL_LOW:        IND_OE_O[k] <= 1'b1;
               `DRLB_SEL_RELEASE:    IND_OE_O[k] <= 1'b0;
               `DRLB_SEL_BLINK_ZERO: IND_OE_O[k] <= ~blink_source_zero;
               `DRLB_SEL_BLINK_ONE:  IND_OE_O[k] <= ~blink_source_one;
               default:              IND_OE_O[k] <= 1'b0;
            endcase
         end
      end
   end

   // Serial slave engine: samples on clock rise, drives on clock fall.
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         state_r                      <= ST_IDLE;
         bit_r                        <= 4'h0;
         shift_r                      <= 8'h00;
         ack_phase_r                  <= 1'b0;
         ptr_r                        <= 3'h0;
         auto_r                       <= 1'b0;
         SDA_O                        <= 1'b0;
         SDA_OE_O                     <= 1'b0;
         zero_prescaler_r             <= `DRLB_RST_PRESCALER; // see [RULE_12]
         blink_zero_duty_threshold_r  <= `DRLB_RST_DUTY;
         blink_one_period_prescaler_r <= `DRLB_RST_PRESCALER;
         blink_one_duty_threshold_r   <= `DRLB_RST_DUTY;
         output_source_selector_r     <= `DRLB_RST_SELECTOR;
      end
      else if (start_cond)
      begin
         state_r     <= ST_ADDR; // see [RULE_14] see [RULE_13]
         bit_r       <= 4'h0;
         ack_phase_r <= 1'b0;
         SDA_OE_O    <= 1'b0;
      end
      else if (stop_cond)
      begin
         state_r  <= ST_IDLE;
         SDA_OE_O <= 1'b0;
      end
      else if (state_r != ST_IDLE && state_r != ST_SKIP)
      begin
         if (scl_rise && !ack_phase_r)
         begin
            if (state_r == ST_RD)
               bit_r <= bit_r + 4'h1;
            else
            begin
               shift_r <= {shift_r[6:0], sda};
               bit_r   <= bit_r + 4'h1;
            end
         end
         else if (scl_rise && ack_phase_r && state_r == ST_RACK)
         begin
            state_r <= sda ? ST_SKIP : ST_RD; // see [RULE_20] see [RULE_18]
         end
         else if (scl_fall && !ack_phase_r && bit_r == 4'h8)
         begin
            // Byte complete (see [RULE_16]); enter the acknowledge slot.
            ack_phase_r <= 1'b1;
            bit_r       <= 4'h0;
            case (state_r)
               ST_ADDR:
               begin
                  if (shift_r[7:1] == SLAVE_ADDR)
                  begin
                     SDA_OE_O <= 1'b1; // see [RULE_17] see [RULE_19]
                     state_r  <= shift_r[0] ? ST_RD : ST_CMD;
                  end
                  else
                     state_r <= ST_SKIP;
               end
               ST_CMD:
               begin
                  SDA_OE_O <= 1'b1; // see [RULE_17]
                  ptr_r    <= shift_r[2:0]; // see [RULE_21]
                  auto_r   <= shift_r[`DRLB_CMD_AUTO_STEP_BIT];
                  state_r  <= ST_WR;
               end
               ST_WR:
               begin
                  SDA_OE_O <= 1'b1; // see [RULE_17]
                  case (ptr_r) // see [RULE_22] see [RULE_24]
                     `DRLB_PTR_ZERO_PRESCALER: zero_prescaler_r             <= shift_r;
                     `DRLB_PTR_ZERO_DUTY:      blink_zero_duty_threshold_r  <= shift_r;
                     `DRLB_PTR_ONE_PRESCALER:  blink_one_period_prescaler_r <= shift_r;
                     `DRLB_PTR_ONE_DUTY:       blink_one_duty_threshold_r   <= shift_r;
                     `DRLB_PTR_SELECTOR:       output_source_selector_r     <= shift_r;
                     default:                  ptr_r <= ptr_r;
                  endcase
                  if (auto_r)
                     ptr_r <= next_ptr(ptr_r); // see [RULE_21]
               end
               ST_RD:
               begin
                  SDA_OE_O <= 1'b0; // see [RULE_20]
                  state_r  <= ST_RACK;
                  if (auto_r)
                     ptr_r <= next_ptr(ptr_r);
               end
               default:
                  state_r <= ST_SKIP;
            endcase
         end
         else if (scl_fall && ack_phase_r)
         begin
            // Acknowledge slot over; load next read byte if transmitting.
            ack_phase_r <= 1'b0;
            SDA_OE_O    <= 1'b0;
            if (state_r == ST_RD)
            begin
               shift_r  <= {rd_byte[6:0], 1'b0};
               SDA_OE_O <= ~rd_byte[7];
            end
         end
         else if (scl_fall && state_r == ST_RD && bit_r != 4'h8)
         begin
            shift_r  <= shift_r << 1;
            SDA_OE_O <= ~shift_r[7];
         end
      end
   end
endmodule // drlb_top

// >>> tb/drlb_sva.sv
// Port checker for the dual rate indicator blinker.
`timescale 1ns/1ns
module drlb_sva #(
   parameter       STEP_CYCLES = 2,
   parameter [6:0] SLAVE_ADDR  = 7'h62
)(
   input wire       MCLK_I,
   input wire       RESET_I,
   input wire       SCL_I,
   input wire       SDA_I,
   input wire       SDA_O,
   input wire       SDA_OE_O,
   input wire [3:0] IND_I,
   input wire [3:0] IND_O,
   input wire [3:0] IND_OE_O
);
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RESET_I);
   a_reset_quiet: assert property (disable iff (1'b0) RESET_I |=> !SDA_OE_O && IND_OE_O == 4'h0)
      else $error("outputs active in reset");
   a_idle_ind: assert property ($fell(RESET_I) |-> (IND_OE_O == 4'h0) [*8])
      else $error("indicator driven after reset");
   a_idle_bus: assert property ($fell(RESET_I) |-> (!SDA_OE_O) [*8])
      else $error("data line driven after reset");
   a_sda_drain: assert property (SDA_O == 1'b0)
      else $error("data line driven high");
   a_ind_drain: assert property (IND_O == 4'h0)
      else $error("indicator driven high");
   a_high_stable: assert property ($rose(SCL_I) |=> $stable(SDA_OE_O) [*5])
      else $error("data changed while clock high");
   a_turn_low: assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I))
      else $error("data turned outside clock low");
   a_ack_hold: assert property ($rose(SDA_OE_O) |-> SDA_OE_O throughout (##[1:12] SCL_I))
      else $error("data released before clock high");
endmodule // drlb_sva
bind drlb_top drlb_sva #(.STEP_CYCLES(STEP_CYCLES), .SLAVE_ADDR(SLAVE_ADDR)) u_sva (.MCLK_I(MCLK_I),
   .RESET_I(RESET_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .IND_I(IND_I),
   .IND_O(IND_O), .IND_OE_O(IND_OE_O));

// >>> tb/drlb_master.sv
// Two-wire bus master model; its clock stands high outside frames.
`timescale 1ns/1ns
module drlb_master (
   input  wire sda_i,
   output reg  scl_o,
   output reg  sda_oe_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task bit_io(input logic b, output logic r);
   begin
      sda_oe_o = !b;
      #31 scl_o = 1'b1;
      #31 r = sda_i;
      #32 scl_o = 1'b0;
      #31;
   end
   endtask
   task start;
   begin
      sda_oe_o = 1'b0;
      #31 scl_o = 1'b1;
      #62 sda_oe_o = 1'b1;
      #62 scl_o = 1'b0;
   end
   endtask
   task stop;
   begin
      sda_oe_o = 1'b1;
      #31 scl_o = 1'b1;
      #62 sda_oe_o = 1'b0;
      #62;
   end
   endtask
   task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      integer i;
   begin
      for (i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ack_in, ack);
   end
   endtask
endmodule // drlb_master

// >>> tb/tb_dual_rate_led_blinker.sv
// Self-checking bench for the dual rate indicator blinker.
`timescale 1ns/1ns
`include "drlb_regs.vh"
module tb_dual_rate_led_blinker;
   reg         clk, rst, ai, a, p0, p1;
   reg  [3:0]  ext_lo;
   reg  [31:0] lfsr;
   reg  [7:0]  regs [0:5];
   reg  [7:0]  q, d0, d1;
   reg  [2:0]  ptr;
   wire        scl, m_oe, sda_oe;
   wire [3:0]  ind_oe;
   wire        sda = !(m_oe | sda_oe);
   wire [3:0]  ind = ~(ind_oe | ext_lo);
   integer     mismatches, n_compared, k, it, hi0, hi1, r0, r1, on0;
   drlb_top #(.STEP_CYCLES(2)) dut (.MCLK_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
      .SDA_OE_O(sda_oe), .IND_I(ind), .IND_O(), .IND_OE_O(ind_oe));
   drlb_master mst (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      rnd = lfsr[7:0];
   endfunction
   function [7:0] pins();
      integer j;
   begin
      pins = 8'h00;
      for (j = 0; j < 4; j++) pins[j] = (regs[5][2*j +: 2] != 2'h0) && !ext_lo[j];
   end
   endfunction
   task chk(input logic [15:0] got, input logic [15:0] exp);
   begin
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task close_out;
   begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   task step;
      if (ai) ptr = (ptr == `DRLB_PTR_LAST) ? 3'h0 : ptr + 3'h1;
   endtask
   task wr(input logic [7:0] d);
   begin
      mst.xfer(d, 1'b1, q, a);
      chk({15'h0, a}, 16'h0);
   end
   endtask
   task put(input logic [7:0] d);
   begin
      wr(d);
      if (ptr != 3'h0) regs[ptr] = d;
      step;
   end
   endtask
   task get(input logic last);
   begin
      mst.xfer(8'hFF, last, q, a);
      chk({8'h0, q}, {8'h0, (ptr == 3'h0) ? pins() : regs[ptr]});
      step;
   end
   endtask
   task setp(input logic [7:0] cmd);
   begin
      mst.start;
      wr({`DRLB_SLAVE_ADDR, 1'b0});
      wr(cmd);
      ptr = cmd[2:0];
      ai = cmd[`DRLB_CMD_AUTO_STEP_BIT];
   end
   endtask
   task rdall(input integer n);
   begin
      mst.start;
      wr({`DRLB_SLAVE_ADDR, 1'b1});
      for (k = 0; k < n; k++) get(k == n - 1);
      mst.stop;
   end
   endtask
   task twin;
   begin
      mst.stop;
      @(negedge clk) ext_lo = rnd();
   end
   endtask
   initial
   begin
      #1000000 mismatches++;
      close_out;
   end
   initial
   begin
      rst = 1'b1;
      ext_lo = 4'h0;
      lfsr = 32'hE91B;
      mismatches = 0;
      n_compared = 0;
      regs[0] = 8'h00;
      regs[1] = 8'hFF;
      regs[2] = 8'h80;
      regs[3] = 8'hFF;
      regs[4] = 8'h80;
      regs[5] = 8'h55;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk({12'h0, ind_oe}, 16'h0);
      mst.start;
      mst.xfer({`DRLB_SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
      chk({15'h0, a}, 16'h1);
      twin;
      setp(8'h11);
      rdall(6);
      setp(8'h10);
      for (k = 0; k < 7; k++) put((ptr == 3'h5) ? (rnd() & 8'h55) : rnd());
      twin;
      setp(8'h11);
      rdall(6);
      setp(8'h02);
      rdall(2);
      setp(8'h00);
      rdall(2);
      for (it = 0; it < 3; it++)
      begin
         d0 = (it == 0) ? 8'h00 : rnd();
         d1 = (it == 0) ? 8'h00 : rnd();
         setp(8'h11);
         put(8'h00);
         put(d0);
         put(8'h02);
         put(d1);
         put(8'hE4);
         mst.stop;
         repeat (1536) @(negedge clk);
         {hi0, hi1, r0, r1, on0} = 0;
         p0 = !ind_oe[2];
         p1 = !ind_oe[3];
         repeat (1536)
         begin
            @(negedge clk);
            hi0 += !ind_oe[2];
            hi1 += !ind_oe[3];
            r0 += !p0 && !ind_oe[2];
            r1 += !p1 && !ind_oe[3];
            on0 += ind_oe[0] && !ind_oe[1];
            p0 = !ind_oe[2];
            p1 = !ind_oe[3];
         end
         chk(hi0[15:0], (d0 == 8'h00) ? 16'h0 : 16'h6 * (16'h100 - {8'h0, d0}));
         chk(hi1[15:0], (d1 == 8'h00) ? 16'h0 : 16'h6 * (16'h100 - {8'h0, d1}));
         chk(r0[15:0], (d0 == 8'h00) ? 16'h0 : 16'h3);
         chk(r1[15:0], (d1 == 8'h00) ? 16'h0 : 16'h1);
         chk(on0[15:0], 16'h600);
      end
      close_out;
   end
endmodule // tb_dual_rate_led_blinker
